/* rtl/codec_ctrl_pkg.sv */
// Constants for the codec secondary control register bank
package codec_ctrl_pkg;
    // Secondary word layout
    localparam int WORD_W = 16;
    localparam int CNT_W = 5;
    localparam logic [4:0] LAST_BIT = 5'h0F;
    localparam int PFX_HI = 15;
    localparam int PFX_LO = 14;
    localparam int RW_BIT = 13;
    localparam int ADDR_HI = 12;
    localparam int ADDR_LO = 8;
    localparam int DATA_HI = 7;
    // Register addresses
    localparam logic [4:0] ADDR_NOP = 5'h00;
    localparam logic [4:0] ADDR_CTRL1 = 5'h01;
    localparam logic [4:0] ADDR_CTRL2 = 5'h02;
    // Control one fields
    localparam int C1_SWRST = 7;
    localparam int C1_PWDN = 6;
    localparam int C1_AUX_IN = 5;
    localparam int C1_MON_AUX = 4;
    localparam int C1_GAIN_HI = 3;
    localparam int C1_GAIN_LO = 2;
    localparam int C1_LOOP = 1;
    localparam int C1_MODE16 = 0;
    // Control two fields
    localparam int C2_OVF = 5;
    localparam int C2_FLAG1 = 4;
    localparam int C2_FLAG0 = 3;
    localparam int C2_PHONE = 2;
    // Reset values and masks
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] CTRL1_STORE_MASK = 8'h7F;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage : codec_ctrl_pkg

/* rtl/codec_secondary_control_regs.sv */
// Secondary serial control register bank of a voice codec
`timescale 1ns/100ps
// Notes on behaviour
// RULE1 - Word bits 12..8 hold register address, bits 7..0 hold data.
// RULE2 - Bit 13 low means write cycle, high means read cycle.
// RULE3 - With bits 15,14 zero: address 0 no-op, 1 control one, 2 control two.
// RULE4 - Control one bit 7 gives one-shot soft reset, clearing itself.
// RULE5 - Control one bit 6 set powers down analog section and filters.
// RULE6 - Control one bit 5 selects auxiliary input pair, else main pair.
// RULE7 - Control one bit 4 selects monitor source: zero main, one auxiliary.
// RULE8 - Control one bits 3:2 set monitor gain; 00 mutes.
// RULE9 - Control one bit 1 set asserts digital loopback.
// RULE10 - Control one bit 0 set selects 16-bit mode, hardware secondary requests.
// RULE11 - Both control registers reset to all zeros; control two bits 5..3 still read the synchronised status inputs.
// RULE12 - Control two bit 5 reads decimator overflow; written value ignored.
// RULE13 - Control two bits 4,3 read flag levels; bit 2 enables phone mode.
// RULE14 - Host should write zeros to reserved bits; device ignores them.
// RULE15 - Read data returns in low byte of output word; unmapped accesses do nothing.
module codec_secondary_control_regs (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Serial link
    input wire logic link_sclk,
    input wire logic fs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    // Status inputs
    input wire logic fir_overflow,
    input wire logic flag1_level,
    input wire logic flag0_level,
    // Control outputs
    output logic soft_reset,
    output logic power_down,
    output logic aux_input_select,
    output logic monitor_aux_select,
    output logic [1:0] monitor_gain,
    output logic digital_loopback,
    output logic mode16,
    output logic phone_mode
);
    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: reset synchroniser
    logic lrst_n_s1_q;
    logic lrst_n_q;
    always_ff @(posedge link_sclk) begin
        lrst_n_s1_q <= rstn;
        lrst_n_q <= lrst_n_s1_q;
    end

    // Link domain: frame receive and transmit
    logic [codec_ctrl_pkg::CNT_W-1:0] bit_cnt_q;
    logic [codec_ctrl_pkg::WORD_W-1:0] rx_shift_q;
    logic [codec_ctrl_pkg::WORD_W-1:0] rx_word_q;
    logic [codec_ctrl_pkg::WORD_W-1:0] tx_shift_q;
    logic rx_tog_q;
    logic dout_oe_q;
    logic [7:0] rd_s1_q;
    logic [7:0] rd_s2_q;
    // Read byte held on the system side
    logic [7:0] rd_data_q;
    wire in_frame = ~fs_n;
    wire bit_room = (bit_cnt_q <= codec_ctrl_pkg::LAST_BIT);
    wire last_bit = in_frame && (bit_cnt_q == codec_ctrl_pkg::LAST_BIT);
    wire [codec_ctrl_pkg::WORD_W-1:0] rx_next = {rx_shift_q[codec_ctrl_pkg::WORD_W-2:0], din};
    wire [codec_ctrl_pkg::WORD_W-1:0] tx_load = {codec_ctrl_pkg::ZERO_BYTE, rd_s2_q};

    // Bit counter, restarted whenever the frame line is idle
    always_ff @(posedge link_sclk) begin
        if (!lrst_n_q || !in_frame) begin
            bit_cnt_q <= '0;
        end else if (bit_room) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    // Shift in the word, hand it over by toggle on the last bit
    always_ff @(posedge link_sclk) begin
        if (!lrst_n_q) begin
            rx_shift_q <= '0;
            rx_word_q <= '0;
            rx_tog_q <= 1'b0;
        end else if (in_frame && bit_room) begin
            rx_shift_q <= rx_next;
            if (last_bit) begin
                rx_word_q <= rx_next; // [RULE1]
                rx_tog_q <= ~rx_tog_q;
            end
        end
    end

    // Read data level crossing, stable between frames
    always_ff @(posedge link_sclk) begin
        rd_s1_q <= rd_data_q;
        rd_s2_q <= rd_s1_q;
    end

    // Output word loaded while idle, shifted during the frame
    always_ff @(posedge link_sclk) begin
        if (!lrst_n_q) begin
            tx_shift_q <= '0;
            dout_oe_q <= 1'b0;
        end else if (!in_frame) begin
            tx_shift_q <= tx_load; // [RULE15]
            dout_oe_q <= 1'b0;
        end else begin
            tx_shift_q <= {tx_shift_q[codec_ctrl_pkg::WORD_W-2:0], 1'b0};
            dout_oe_q <= bit_room;
        end
    end
    assign dout = tx_shift_q[codec_ctrl_pkg::WORD_W-1];
    assign dout_oe = dout_oe_q;

    // Link domain checks, held off while the link side is in reset
    a_cnt_idle: assert property (@(posedge link_sclk) disable iff (!lrst_n_q) // [RULE1]
        !in_frame |=> bit_cnt_q == 5'h00)
        else $error("bit counter not cleared between frames");
    a_cnt_stop: assert property (@(posedge link_sclk) disable iff (!lrst_n_q) // [RULE1]
        in_frame && !bit_room |=> bit_cnt_q == $past(bit_cnt_q))
        else $error("bit counter moved past the last bit");
    a_word_take: assert property (@(posedge link_sclk) disable iff (!lrst_n_q) // [RULE1]
        last_bit |=> rx_word_q == $past(rx_next))
        else $error("received word not latched on the last bit");
    a_tog_flip: assert property (@(posedge link_sclk) disable iff (!lrst_n_q) // [RULE1]
        last_bit |=> rx_tog_q != $past(rx_tog_q))
        else $error("word handover toggle did not flip");
    a_extra_bits: assert property (@(posedge link_sclk) disable iff (!lrst_n_q) // [RULE1]
        in_frame && !bit_room |=> $stable(rx_word_q) && $stable(rx_tog_q))
        else $error("bits beyond the word changed the received word");
    a_oe_idle: assert property (@(posedge link_sclk) disable iff (!lrst_n_q) // [RULE15]
        !in_frame |=> !dout_oe)
        else $error("output enabled outside a frame");
    a_oe_frame: assert property (@(posedge link_sclk) disable iff (!lrst_n_q) // [RULE15]
        in_frame && bit_room |=> dout_oe)
        else $error("output not enabled during the word");
    a_msb_first: assert property (@(posedge link_sclk) disable iff (!lrst_n_q) // [RULE15]
        in_frame |=> dout == $past(tx_shift_q[codec_ctrl_pkg::WORD_W-2]))
        else $error("return word not shifted msb first");

    ////////////////////////////////////////////////////////////////////////////////
    // System domain: toggle synchroniser for received words
    logic tog_s1_q;
    logic tog_s2_q;
    logic tog_s3_q;
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
        end else begin
            tog_s1_q <= rx_tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end
    wire word_evt = tog_s2_q ^ tog_s3_q;

    // Status input synchronisers
    logic [2:0] stat_s1_q;
    logic [2:0] stat_s2_q;
    always_ff @(posedge clk_sys) begin
        stat_s1_q <= {fir_overflow, flag1_level, flag0_level};
        stat_s2_q <= stat_s1_q;
    end

    // Command decode
    wire [codec_ctrl_pkg::WORD_W-1:0] cmd = rx_word_q;
    wire pfx_ok = ~cmd[codec_ctrl_pkg::PFX_HI] & ~cmd[codec_ctrl_pkg::PFX_LO]; // [RULE3]
    wire [4:0] addr = cmd[codec_ctrl_pkg::ADDR_HI:codec_ctrl_pkg::ADDR_LO]; // [RULE1]
    wire [7:0] wdata = cmd[codec_ctrl_pkg::DATA_HI:0]; // [RULE1]
    wire is_read = cmd[codec_ctrl_pkg::RW_BIT]; // [RULE2]
    wire acc_ok = word_evt & pfx_ok;
    wire hit1 = acc_ok & (addr == codec_ctrl_pkg::ADDR_CTRL1); // [RULE3]
    wire hit2 = acc_ok & (addr == codec_ctrl_pkg::ADDR_CTRL2); // [RULE3]
    wire wr1 = hit1 & ~is_read;
    wire wr2 = hit2 & ~is_read;
    wire rd1 = hit1 & is_read;
    wire rd2 = hit2 & is_read;

    // Control registers
    logic [7:0] ctrl1_q;
    logic [7:0] ctrl1_d;
    logic phone_q;
    logic phone_d;
    logic swrst_q;
    logic swrst_d;
    logic [7:0] rd_data_d;
    assign ctrl1_d = wr1 ? (wdata & codec_ctrl_pkg::CTRL1_STORE_MASK) : ctrl1_q;
    assign swrst_d = wr1 & wdata[codec_ctrl_pkg::C1_SWRST]; // [RULE4]
    assign phone_d = wr2 ? wdata[codec_ctrl_pkg::C2_PHONE] : phone_q; // [RULE13] [RULE14]

    // Readback images; reserved and self-clearing bits read zero
    wire [7:0] ctrl2_img = {2'b00, stat_s2_q, phone_q, 2'b00}; // [RULE12] [RULE13]
    assign rd_data_d = rd1 ? ctrl1_q : (rd2 ? ctrl2_img : rd_data_q); // [RULE15]

    // Register update with synchronous reset to zero
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ctrl1_q <= codec_ctrl_pkg::CTRL1_RST; // [RULE11]
            phone_q <= codec_ctrl_pkg::CTRL2_RST[codec_ctrl_pkg::C2_PHONE]; // [RULE11]
            swrst_q <= 1'b0;
            rd_data_q <= codec_ctrl_pkg::ZERO_BYTE;
        end else begin
            ctrl1_q <= ctrl1_d;
            phone_q <= phone_d;
            swrst_q <= swrst_d;
            rd_data_q <= rd_data_d;
        end
    end

    // Control outputs
    assign soft_reset = swrst_q; // [RULE4]
    assign power_down = ctrl1_q[codec_ctrl_pkg::C1_PWDN]; // [RULE5]
    assign aux_input_select = ctrl1_q[codec_ctrl_pkg::C1_AUX_IN]; // [RULE6]
    assign monitor_aux_select = ctrl1_q[codec_ctrl_pkg::C1_MON_AUX]; // [RULE7]
    assign monitor_gain = ctrl1_q[codec_ctrl_pkg::C1_GAIN_HI:codec_ctrl_pkg::C1_GAIN_LO]; // [RULE8]
    assign digital_loopback = ctrl1_q[codec_ctrl_pkg::C1_LOOP]; // [RULE9]
    assign mode16 = ctrl1_q[codec_ctrl_pkg::C1_MODE16]; // [RULE10]
    assign phone_mode = phone_q; // [RULE13]

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions, system domain
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_ctrl1_write: assert property (wr1 |=> ctrl1_q == ($past(wdata) & 8'h7F)) // [RULE1]
        else $error("control one did not take written data");
    a_read_keeps: assert property (word_evt && is_read |=> $stable(ctrl1_q) && $stable(phone_q)) // [RULE2]
        else $error("read cycle changed a register");
    a_bad_prefix: assert property (word_evt && !pfx_ok |=> $stable(ctrl1_q) && $stable(rd_data_q)) // [RULE3]
        else $error("word with nonzero prefix had an effect");
    a_nop_address: assert property (word_evt && addr == 5'h00 |=> $stable(ctrl1_q) && $stable(phone_q)) // [RULE3]
        else $error("no-op address changed state");
    a_swrst_pulse: assert property (wr1 && wdata[7] |=> soft_reset ##1 !soft_reset) // [RULE4]
        else $error("software reset was not a single pulse");
    a_swrst_clear: assert property (wr1 |=> !ctrl1_q[7]) // [RULE4]
        else $error("software reset bit did not self clear");
    a_ctrl_map: assert property (wr1 |=> {power_down, aux_input_select, monitor_aux_select,
        monitor_gain, digital_loopback, mode16} == $past(wdata[6:0])) // [RULE5] [RULE8] [RULE10]
        else $error("control outputs do not follow control one");
    a_ctrl2_write: assert property (wr2 |=> phone_mode == $past(wdata[2]) && $stable(ctrl1_q)) // [RULE13]
        else $error("control two write wrong");
    a_ctrl2_read: assert property (rd2 |=> rd_data_q == {2'b00, $past(stat_s2_q), phone_q, 2'b00}) // [RULE13]
        else $error("control two readback wrong");
    a_ctrl1_read: assert property (rd1 |=> rd_data_q == $past(ctrl1_q)) // [RULE15]
        else $error("control one readback wrong");
    a_reset_zero: assert property (@(posedge clk_sys) disable iff (1'b0)
        !rstn |=> ctrl1_q == 8'h00 && !phone_q && !soft_reset) // [RULE11]
        else $error("registers not zero after reset");

    // Field mapping of control one onto the outputs
    a_pwdn_map: assert property ( // [RULE5]
        wr1 |=> power_down == $past(wdata[6]))
        else $error("power down does not follow control one");
    a_aux_map: assert property ( // [RULE6]
        wr1 |=> aux_input_select == $past(wdata[5]))
        else $error("input select does not follow control one");
    a_mon_map: assert property ( // [RULE7]
        wr1 |=> monitor_aux_select == $past(wdata[4]))
        else $error("monitor source does not follow control one");
    a_gain_map: assert property ( // [RULE8]
        wr1 |=> monitor_gain == $past(wdata[3:2]))
        else $error("monitor gain does not follow control one");
    a_loop_map: assert property ( // [RULE9]
        wr1 |=> digital_loopback == $past(wdata[1]))
        else $error("loopback does not follow control one");
    a_mode_map: assert property ( // [RULE10]
        wr1 |=> mode16 == $past(wdata[0]))
        else $error("word mode does not follow control one");

    // Registers hold unless their own write arrives
    a_ctrl1_hold: assert property ( // [RULE5]
        !wr1 |=> $stable(ctrl1_q))
        else $error("control one changed without a write");
    a_phone_hold: assert property ( // [RULE13]
        !wr2 |=> $stable(phone_q))
        else $error("phone mode changed without a write");
    a_phone_kept: assert property ( // [RULE3]
        wr1 |=> $stable(phone_q))
        else $error("control one write touched phone mode");
    a_swrst_cause: assert property ( // [RULE4]
        !(wr1 && wdata[codec_ctrl_pkg::C1_SWRST]) |=> !soft_reset)
        else $error("software reset pulse without a request");
    a_prefix_quiet: assert property ( // [RULE3]
        word_evt && !pfx_ok |=> !soft_reset)
        else $error("word with nonzero prefix caused a reset pulse");
    a_unmapped: assert property ( // [RULE15]
        word_evt && pfx_ok && addr > codec_ctrl_pkg::ADDR_CTRL2 |=> $stable(rd_data_q))
        else $error("unmapped address changed read data");

    // Read data path
    a_rd_stands: assert property ( // [RULE15]
        !(rd1 || rd2) |=> $stable(rd_data_q))
        else $error("read data changed without a read");
    a_write_quiet: assert property ( // [RULE2]
        wr1 || wr2 |=> $stable(rd_data_q))
        else $error("write cycle changed read data");
    a_status_read: assert property ( // [RULE12]
        rd2 |=> rd_data_q[5:3] == $past(stat_s2_q))
        else $error("status levels not returned on read");

    c_write_ctrl1: cover property (wr1 ##[1:200] rd1);
    c_soft_reset: cover property (soft_reset);
    c_phone_on: cover property (wr2 && wdata[2]);
    c_read_ctrl2: cover property (rd2);
    c_link_word: cover property (@(posedge link_sclk) last_bit);
endmodule : codec_secondary_control_regs

/* test/host_serial_port.sv */
// Host serial port model issuing secondary control frames
`timescale 1ns/100ps
module host_serial_port (
    // Serial link towards the codec
    output logic link_sclk,
    output logic fs_n,
    output logic din,
    // Return data from the codec
    input wire logic dout,
    input wire logic dout_oe
);
    // Clock and frame lines idle until a frame is sent
    initial begin
        link_sclk = 1'b0;
        fs_n = 1'b1;
        din = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One 48 ns link clock period, data changes after the fall
    task automatic tick();
        #24 link_sclk = 1'b1;
        #24 link_sclk = 1'b0;
    endtask : tick

    // Link clock with frame sync high
    task automatic idle(input int n);
        repeat (n) tick();
    endtask : idle

    // Whole 16-bit frame, MSB first, return word gathered in parallel
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        r = 16'h0000;
        idle(3);
        fs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            din = w[i];
            r = {r[14:0], dout_oe ? dout : 1'b1};
            tick();
        end
        fs_n = 1'b1;
        din = ~din;
        tick();
    endtask : xfer
endmodule : host_serial_port

/* test/tb_codec_secondary_control_regs.sv */
// Self-checking bench for the codec secondary control register bank
`timescale 1ns/100ps
module tb_codec_secondary_control_regs;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic fir_overflow = 1'b0;
    logic flag1_level = 1'b0;
    logic flag0_level = 1'b0;
    wire logic link_sclk, fs_n, din, dout, dout_oe, soft_reset, power_down, aux_input_select;
    wire logic monitor_aux_select, digital_loopback, mode16, phone_mode;
    wire logic [1:0] monitor_gain;
    wire logic [7:0] ctl1 = {1'b0, power_down, aux_input_select, monitor_aux_select,
        monitor_gain, digital_loopback, mode16};
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;
    int pulses = 0;
    logic [15:0] r;
    logic [7:0] d;
    logic [7:0] pat [4] = '{8'h7E, 8'h01, 8'h54, 8'h28};
    logic [15:0] bad [5] = '{16'h4137, 16'h8237, 16'h0037, 16'h0337, 16'h2137};

    ////////////////////////////////////////////////////////////////////////////////
    // Design, host model and clock
    codec_secondary_control_regs codec_secondary_control_regs_inst (.clk_sys(clk_sys),
        .rstn(rstn), .link_sclk(link_sclk), .fs_n(fs_n), .din(din), .dout(dout),
        .dout_oe(dout_oe), .fir_overflow(fir_overflow), .flag1_level(flag1_level),
        .flag0_level(flag0_level), .soft_reset(soft_reset), .power_down(power_down),
        .aux_input_select(aux_input_select), .monitor_aux_select(monitor_aux_select),
        .monitor_gain(monitor_gain), .digital_loopback(digital_loopback), .mode16(mode16),
        .phone_mode(phone_mode));
    host_serial_port host_inst (.link_sclk(link_sclk), .fs_n(fs_n), .din(din), .dout(dout),
        .dout_oe(dout_oe));
    always #2.5 clk_sys = ~clk_sys;

    // Cycle ceiling and soft reset pulse count
    always @(posedge clk_sys) begin
        cycles++;
        if (soft_reset === 1'b1) pulses++;
        if (cycles == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic test_done();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done

    // Byte comparison
    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp8

    // Any word, then let the update cross into the system domain
    task automatic send(input logic [15:0] w);
        host_inst.xfer(w, r);
        repeat (10) @(posedge clk_sys);
    endtask : send

    // Read frame, answer comes back in the following no-op frame
    task automatic rd(input logic [4:0] a, output logic [7:0] v);
        host_inst.xfer({3'b001, a, 8'h00}, r);
        host_inst.xfer(16'h0000, r);
        v = r[7:0];
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        fork
            host_inst.idle(4);
            repeat (8) @(posedge clk_sys);
        join
        @(posedge clk_sys) rstn <= 1'b1;
        @(posedge clk_sys);
        cmp8("ctl1 outputs", 8'h00, ctl1);
        cmp8("phone and oe", 8'h00, {6'h00, phone_mode, dout_oe});
        rd(5'h01, d);
        cmp8("ctrl1 read", 8'h00, d);
        rd(5'h02, d);
        cmp8("ctrl2 read", 8'h00, d);
        foreach (pat[i]) begin
            send({8'h01, pat[i]});
            cmp8("ctl1 outputs", pat[i], ctl1);
            rd(5'h01, d);
            cmp8("ctrl1 read", pat[i], d);
        end
        pulses = 0;
        send(16'h01D4);
        cmp8("reset pulses", 8'h01, pulses[7:0]);
        rd(5'h01, d);
        cmp8("ctrl1 after reset", 8'h54, d);
        foreach (bad[i]) begin
            send(bad[i]);
            cmp8("ctl1 kept", 8'h54, ctl1);
            cmp8("phone kept", 8'h00, {7'h00, phone_mode});
        end
        @(posedge clk_sys) {fir_overflow, flag1_level, flag0_level} <= 3'b101;
        send(16'h023C);
        cmp8("phone set", 8'h01, {7'h00, phone_mode});
        rd(5'h02, d);
        cmp8("ctrl2 read", 8'h2C, d);
        @(posedge clk_sys) {fir_overflow, flag1_level, flag0_level} <= 3'b010;
        send(16'h0200);
        cmp8("phone clear", 8'h00, {7'h00, phone_mode});
        rd(5'h02, d);
        cmp8("ctrl2 read", 8'h10, d);
        cmp8("ctl1 kept", 8'h54, ctl1);
        test_done();
    end
endmodule : tb_codec_secondary_control_regs
